// file: pmux_regs.svh
`ifndef PMUX_REGS_SVH
`define PMUX_REGS_SVH
// Register byte offsets on the Wishbone slave.
`define PMUX_OFS_PB_PER 8'h00
`define PMUX_OFS_PB_DIR 8'h04
`define PMUX_OFS_PB_DOUT 8'h08
`define PMUX_OFS_PB_PU 8'h0c
`define PMUX_OFS_PF_PER 8'h10
`define PMUX_OFS_PF_DIR 8'h14
`define PMUX_OFS_PF_DOUT 8'h18
`define PMUX_OFS_PF_PU 8'h1c
`define PMUX_OFS_BCR 8'h20
`define PMUX_OFS_CLOCK_OUTPUT_SELECT_REG 8'h24
`define PMUX_OFS_PIN_IN 8'h28
// Field positions.
`define PMUX_PF_LO 9
`define PMUX_PF_HI 15
`define PMUX_DRV_BIT 0
`define PMUX_PIN_IN_PF_LO 16
`define PMUX_ADDR_LO 16
// Reset values.
`define PMUX_PB_PER_RST 8'h00
`define PMUX_PB_PU_RST 8'hff
`define PMUX_PF_PER_RST 7'h7f
`define PMUX_PF_PU_RST 7'h7f
`define PMUX_BOOT_ADDR 4'hf
`define PMUX_BOOT_GPIO 4'h0
`endif

// file: pmux_pkg.sv
package pmux_pkg;
    // Pins of port B: eight lines shared with A16..A23 and clock monitors.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } pmux_pb_pins_t;

    // Pins of port F bits 9..15, shared with data lines D0..D6.
    typedef struct packed {
        logic [6:0] out;
        logic [6:0] oe;
        logic [6:0] pu;
    } pmux_pf_pins_t;

    // Whole state of the pin multiplexer.
    typedef struct packed {
        logic [7:0] per;
        logic [7:0] dir;
        logic [7:0] dout;
        logic [7:0] pu;
        logic [6:0] fper;
        logic [6:0] fdir;
        logic [6:0] fdout;
        logic [6:0] fpu;
        logic drv;
        logic [3:0] clksel;
        logic boot_pend;
        logic ack;
        logic [31:0] rdata;
        pmux_pb_pins_t pb;
        pmux_pf_pins_t pf;
        logic [6:0] din;
        logic [2:0] ctl;
        logic ctl_oe;
    } pmux_state_t;
endpackage

// file: pmux_top.sv
`timescale 1ns/10ps
`include "pmux_regs.svh"

// Summary of operation
// - After reset, port B pins 0-3 become GPIO or address from boot straps.
// - Writing the port B peripheral enable register overrides that startup choice.
// - Each pull-up stays on until software clears its enable bit.
// - Port F pull-up bits are indexed by port bit number, 9 to 15.
// - Port B pins 4-7 leave reset as GPIO inputs with pull-ups on.
// - Port B pins are individually input or output in GPIO function.
// - As address lines, port B pins 4-7 drive address bits 20-23.
// - With drive bit clear, A20-A23 and bus controls float while idle.
// - Pins 4-7 can show prescaler, system, second system, oscillator clocks.
// - A pin's GPIO must be disabled before address or clock takes it.
// - With GPIO disabled, clock select picks address or clock output on pins 4-7; pins 0-3 always carry address.
// - Data lines 0-6 carry bus data and default to bus function.
// - With drive bit clear, data lines 0-6 float while the bus idles.
// - Port F bits 9-15 are individually input or output as GPIO.
// - A16-A19 also float on idle bus under the same drive bit.
module pmux_top import pmux_pkg::*; #(
    parameter int PB_PINS = 8,
    parameter int PF_PINS = 7
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Boot and security straps.
    input wire logic external_boot_select_i,
    input wire logic memory_interface_mode_input_i,
    input wire logic flash_secure_i,
    // External memory interface side.
    input wire logic emi_active_i,
    input wire logic [23:16] emi_addr_i,
    input wire logic [6:0] emi_dout_i,
    input wire logic emi_dout_en_i,
    input wire logic [2:0] emi_ctl_i,
    output logic [6:0] emi_din_o,
    // Clocks to monitor, sampled as ordinary inputs.
    input wire logic prescaler_clock_i,
    input wire logic system_clock_i,
    input wire logic second_system_clock_i,
    input wire logic oscillator_clock_i,
    // Pads.
    input wire logic [7:0] pb_in_i,
    output pmux_pb_pins_t pb_o,
    input wire logic [6:0] pf_in_i,
    output pmux_pf_pins_t pf_o,
    output logic [2:0] mem_ctl_o,
    output logic mem_ctl_oe_o
);
    if (PB_PINS != 8 || PF_PINS != 7) begin : g_chk
        $error("pmux_top supports only 8 port B and 7 port F pins.");
    end

    pmux_state_t s;
    pmux_state_t next_s;
    logic boot_addr;
    logic req;
    logic wr;
    logic [7:0] clk_mon;
    logic [7:0] clk_pick;

    // Byte-lane merge used by every port B and port F register.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] dat,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = dat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Reset image; the boot decision is deferred until after release.
    function automatic pmux_state_t rst_state();
        pmux_state_t r;
        r = '0;
        r.per = `PMUX_PB_PER_RST;
        r.pu = `PMUX_PB_PU_RST;
        r.fper = `PMUX_PF_PER_RST;
        r.fpu = `PMUX_PF_PU_RST;
        r.boot_pend = 1'b1;
        r.pb.pu = `PMUX_PB_PU_RST;
        r.pf.pu = `PMUX_PF_PU_RST;
        return r;
    endfunction

    // Address function at boot when booting externally, or when the
    // interface mode asks for it and the flash is not secured.
    assign boot_addr = external_boot_select_i |
                       (memory_interface_mode_input_i & ~flash_secure_i);
    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & s.ack;
    assign clk_mon = {oscillator_clock_i, second_system_clock_i,
                      system_clock_i, prescaler_clock_i, 4'h0};
    assign clk_pick = {s.clksel, 4'h0};

    // Next-state logic: straps, bus slave and pin multiplexing.
    always_comb begin
        logic [31:0] m;
        m = '0;
        next_s = s;
        next_s.ack = 1'b0;
        next_s.rdata = '0;
        if (s.boot_pend) begin
            next_s.per[3:0] = boot_addr ? `PMUX_BOOT_ADDR : `PMUX_BOOT_GPIO;
            next_s.boot_pend = 1'b0;
        end
        // Answer one cycle after the request; ack drops the cycle after.
        if (req && !s.ack) begin
            next_s.ack = 1'b1;
            case (wb_adr_i)
                `PMUX_OFS_PB_PER: next_s.rdata[7:0] = s.per;
                `PMUX_OFS_PB_DIR: next_s.rdata[7:0] = s.dir;
                `PMUX_OFS_PB_DOUT: next_s.rdata[7:0] = s.dout;
                `PMUX_OFS_PB_PU: next_s.rdata[7:0] = s.pu;
                `PMUX_OFS_PF_PER:
                    next_s.rdata[`PMUX_PF_HI:`PMUX_PF_LO] = s.fper;
                `PMUX_OFS_PF_DIR:
                    next_s.rdata[`PMUX_PF_HI:`PMUX_PF_LO] = s.fdir;
                `PMUX_OFS_PF_DOUT:
                    next_s.rdata[`PMUX_PF_HI:`PMUX_PF_LO] = s.fdout;
                `PMUX_OFS_PF_PU:
                    next_s.rdata[`PMUX_PF_HI:`PMUX_PF_LO] = s.fpu;
                `PMUX_OFS_BCR: next_s.rdata[`PMUX_DRV_BIT] = s.drv;
                `PMUX_OFS_CLOCK_OUTPUT_SELECT_REG: next_s.rdata[3:0] = s.clksel;
                `PMUX_OFS_PIN_IN: begin
                    next_s.rdata[7:0] = pb_in_i;
                    next_s.rdata[`PMUX_PIN_IN_PF_LO +: 7] = pf_in_i;
                end
                default: next_s.rdata = '0;
            endcase
        end
        // Writes land on the edge where the master sees ack; placed after
        // the strap decision so that software always wins.
        if (wr) begin
            case (wb_adr_i)
                `PMUX_OFS_PB_PER: begin
                    m = merge({24'h0, s.per}, wb_dat_i, wb_sel_i);
                    next_s.per = m[7:0];
                    next_s.boot_pend = 1'b0;
                end
                `PMUX_OFS_PB_DIR: begin
                    m = merge({24'h0, s.dir}, wb_dat_i, wb_sel_i);
                    next_s.dir = m[7:0];
                end
                `PMUX_OFS_PB_DOUT: begin
                    m = merge({24'h0, s.dout}, wb_dat_i, wb_sel_i);
                    next_s.dout = m[7:0];
                end
                `PMUX_OFS_PB_PU: begin
                    m = merge({24'h0, s.pu}, wb_dat_i, wb_sel_i);
                    next_s.pu = m[7:0];
                end
                `PMUX_OFS_PF_PER: begin
                    m = merge({16'h0, s.fper, 9'h0}, wb_dat_i, wb_sel_i);
                    next_s.fper = m[`PMUX_PF_HI:`PMUX_PF_LO];
                end
                `PMUX_OFS_PF_DIR: begin
                    m = merge({16'h0, s.fdir, 9'h0}, wb_dat_i, wb_sel_i);
                    next_s.fdir = m[`PMUX_PF_HI:`PMUX_PF_LO];
                end
                `PMUX_OFS_PF_DOUT: begin
                    m = merge({16'h0, s.fdout, 9'h0}, wb_dat_i, wb_sel_i);
                    next_s.fdout = m[`PMUX_PF_HI:`PMUX_PF_LO];
                end
                `PMUX_OFS_PF_PU: begin
                    m = merge({16'h0, s.fpu, 9'h0}, wb_dat_i, wb_sel_i);
                    next_s.fpu = m[`PMUX_PF_HI:`PMUX_PF_LO];
                end
                `PMUX_OFS_BCR: begin
                    if (wb_sel_i[0]) begin
                        next_s.drv = wb_dat_i[`PMUX_DRV_BIT];
                    end
                end
                `PMUX_OFS_CLOCK_OUTPUT_SELECT_REG: begin
                    if (wb_sel_i[0]) begin
                        next_s.clksel = wb_dat_i[3:0];
                    end
                end
                default: next_s.drv = s.drv;
            endcase
        end
        next_s.pb.pu = s.pu;
        next_s.pf.pu = s.fpu;
        for (int i = 0; i < 8; i++) begin
            if (!s.per[i]) begin
                next_s.pb.out[i] = s.dout[i];
                next_s.pb.oe[i] = s.dir[i];
            end else if (clk_pick[i]) begin
                next_s.pb.out[i] = clk_mon[i];
                next_s.pb.oe[i] = 1'b1;
            end else begin
                next_s.pb.out[i] = emi_addr_i[`PMUX_ADDR_LO + i];
                next_s.pb.oe[i] = emi_active_i | s.drv;
            end
        end
        for (int j = 0; j < 7; j++) begin
            if (!s.fper[j]) begin
                next_s.pf.out[j] = s.fdout[j];
                next_s.pf.oe[j] = s.fdir[j];
            end else begin
                next_s.pf.out[j] = emi_dout_i[j];
                next_s.pf.oe[j] = emi_active_i ? emi_dout_en_i : s.drv;
            end
        end
        next_s.din = pf_in_i;
        // control signals float on idle bus unless the drive bit is set
        next_s.ctl = emi_ctl_i;
        next_s.ctl_oe = emi_active_i | s.drv;
    end

    // State register; reset holds data drivers off with pull-ups on.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= rst_state();
        end else begin
            s <= next_s;
        end
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdata;
    assign pb_o = s.pb;
    assign pf_o = s.pf;
    assign emi_din_o = s.din;
    assign mem_ctl_o = s.ctl;
    assign mem_ctl_oe_o = s.ctl_oe;

    default clocking cb @(posedge clk_i); endclocking

    // Checks on the multiplexer behaviour.
    boot_apply_a: assert property (disable iff (rst_i)
        s.boot_pend && !wr |=> s.per[3:0] == {4{$past(boot_addr)}})
        else $error("Boot pin function not applied.");
    per_write_a: assert property (disable iff (rst_i)
        wr && wb_adr_i == `PMUX_OFS_PB_PER && wb_sel_i[0]
        |=> s.per == $past(wb_dat_i[7:0]) ##1 !s.boot_pend)
        else $error("Peripheral enable write lost.");
    pullup_hold_a: assert property (disable iff (rst_i)
        !(wr && wb_adr_i == `PMUX_OFS_PB_PU) |=> $stable(s.pu))
        else $error("Pull-up changed without a write.");
    pf_pullup_a: assert property (disable iff (rst_i)
        wr && wb_adr_i == `PMUX_OFS_PF_PU && wb_sel_i[1]
        |=> ##1 pf_o.pu == $past(wb_dat_i[15:9], 2))
        else $error("Port F pull-up not indexed by bit.");
    reset_gpio_a: assert property (disable iff (rst_i)
        $past(rst_i) |-> s.per[7:4] == 4'h0 && pb_o.oe[7:4] == 4'h0
        && pb_o.pu[7:4] == 4'hf)
        else $error("Pins 4-7 not GPIO inputs after reset.");
    gpio_dir_a: assert property (disable iff (rst_i)
        wr && wb_adr_i == `PMUX_OFS_PB_DIR && wb_sel_i[0] && !s.per[4]
        && !$past(wr) |=> ##1 pb_o.oe[4] == $past(wb_dat_i[4], 2))
        else $error("GPIO direction not applied.");
    addr_drive_a: assert property (disable iff (rst_i)
        s.per[5] && !s.clksel[1] && emi_active_i
        |=> pb_o.out[5] == $past(emi_addr_i[21]) && pb_o.oe[5])
        else $error("Address line 21 not driven.");
    idle_float_a: assert property (disable iff (rst_i)
        s.per[0] && !s.drv && !emi_active_i |=> !pb_o.oe[0] && !mem_ctl_oe_o)
        else $error("Address or control driven on idle bus.");
    clk_mon_a: assert property (disable iff (rst_i)
        s.per[7] && s.clksel[3]
        |=> pb_o.out[7] == $past(oscillator_clock_i) && pb_o.oe[7])
        else $error("Oscillator clock not on pin 7.");
    data_default_a: assert property (disable iff (rst_i)
        $past(rst_i) |-> s.fper == `PMUX_PF_PER_RST)
        else $error("Data pins not in bus function after reset.");
    data_idle_a: assert property (disable iff (rst_i)
        s.fper[0] && !s.drv && !emi_active_i |=> !pf_o.oe[0])
        else $error("Data line driven on idle bus.");
    reset_data_a: assert property (
        rst_i |=> pf_o.oe == 7'h00 && pf_o.pu == `PMUX_PF_PU_RST)
        else $error("Data pins not safe during reset.");
    drv_latency_a: assert property (disable iff (rst_i)
        wr && wb_adr_i == `PMUX_OFS_BCR && wb_sel_i[0] && wb_dat_i[0]
        |=> ##1 mem_ctl_oe_o)
        else $error("Drive bit not on pins in time.");
endmodule // pmux_top

// file: pmux_mem_model.sv
`timescale 1ns/10ps
// Pads of ports B and F with the external memory hanging on D0..D6.
module pmux_mem_model import pmux_pkg::*; (
    // Clock.
    input wire logic clk_i,
    // Pin drivers of the block.
    input wire pmux_pb_pins_t pb_i,
    input wire pmux_pf_pins_t pf_i,
    // Memory answer to a read on D0..D6.
    input wire logic mem_rd_i,
    input wire logic [6:0] mem_dat_i,
    // Resolved pad levels.
    output logic [7:0] pb_pad_o,
    output logic [6:0] pf_pad_o
);
    logic [7:0] pb_last;
    logic [6:0] pf_last;

    // Last levels, so a floating pad can show their inverse.
    always_ff @(posedge clk_i) begin
        pb_last <= pb_pad_o;
        pf_last <= pf_pad_o;
    end

    // A floating pad without pull-up toggles, so no stale value passes.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pb_pad_o[i] = pb_i.oe[i] ? pb_i.out[i]
                                     : (pb_i.pu[i] | ~pb_last[i]);
        end
        for (int i = 0; i < 7; i++) begin
            pf_pad_o[i] = pf_i.oe[i] ? pf_i.out[i] : mem_rd_i ? mem_dat_i[i]
                                     : (pf_i.pu[i] | ~pf_last[i]);
        end
    end
endmodule // pmux_mem_model

// file: ext_bus_gpio_pin_mux_tb.sv
`timescale 1ns/10ps
module ext_bus_gpio_pin_mux_tb import pmux_pkg::*;;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, pb_in_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic external_boot_select_i, memory_interface_mode_input_i;
    logic flash_secure_i, emi_active_i, emi_dout_en_i, mem_ctl_oe_o, mem_rd;
    logic [23:16] emi_addr_i;
    logic [6:0] emi_dout_i, emi_din_o, pf_in_i, mem_dat;
    logic [2:0] emi_ctl_i, mem_ctl_o;
    logic prescaler_clock_i, system_clock_i;
    logic second_system_clock_i, oscillator_clock_i;
    pmux_pb_pins_t pb_o;
    pmux_pf_pins_t pf_o;
    int bad_count = 0;
    int checks = 0;

    pmux_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .external_boot_select_i,
        .memory_interface_mode_input_i, .flash_secure_i, .emi_active_i,
        .emi_addr_i, .emi_dout_i, .emi_dout_en_i, .emi_ctl_i, .emi_din_o,
        .prescaler_clock_i, .system_clock_i, .second_system_clock_i,
        .oscillator_clock_i, .pb_in_i, .pb_o, .pf_in_i, .pf_o, .mem_ctl_o,
        .mem_ctl_oe_o);

    pmux_mem_model mem (.clk_i, .pb_i(pb_o), .pf_i(pf_o), .mem_rd_i(mem_rd),
        .mem_dat_i(mem_dat), .pb_pad_o(pb_in_i), .pf_pad_o(pf_in_i));

    // The 25 MHz system clock.
    always #20 clk_i = ~clk_i;

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask

    // One classic cycle; ack is sampled at the edge, then the bus is freed.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= 4'hf;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic external_memory_interface(input logic act, input logic den);
        @(posedge clk_i);
        emi_active_i <= act;
        emi_dout_en_i <= den;
        step(2);
    endtask

    task automatic t_reset;
        wb(1'b0, 8'h00, 32'h0);
        chk("strap per", 32'h0000000f, q);
        chk("pb oe", 32'h0, pb_o.oe);
        chk("pb pu", 32'h000000ff, pb_o.pu);
        wb(1'b0, 8'h28, 32'h0);
        chk("pad read", 32'h007f00ff, q);
        wb(1'b0, 8'h3c, 32'h0);
        chk("unmapped", 32'h0, q);
    endtask

    task automatic t_gpio;
        wb(1'b1, 8'h00, 32'h0);
        wb(1'b1, 8'h04, 32'ha5);
        wb(1'b1, 8'h08, 32'h3c);
        step(1);
        chk("pb oe", 32'ha5, pb_o.oe);
        chk("pb out", 32'h3c, pb_o.out);
        wb(1'b0, 8'h28, 32'h0);
        chk("pb pads", 32'h0000007e, q & 32'hff);
    endtask

    task automatic t_pullup;
        wb(1'b1, 8'h0c, 32'hf0);
        step(1);
        chk("pb pu", 32'hf0, pb_o.pu);
        wb(1'b1, 8'h1c, 32'hfc00);
        step(1);
        chk("pf pu", 32'h7e, pf_o.pu);
    endtask

    task automatic t_addr;
        wb(1'b1, 8'h00, 32'hff);
        emi_addr_i <= 8'h9b;
        emi_ctl_i <= 3'h2;
        external_memory_interface(1'b1, 1'b0);
        chk("addr out", 32'h9b, pb_o.out);
        chk("addr oe", 32'hff, pb_o.oe);
        chk("ctl out", 32'h2, mem_ctl_o);
        external_memory_interface(1'b0, 1'b0);
        chk("idle oe", 32'h0, pb_o.oe);
        chk("ctl oe", 32'h0, mem_ctl_oe_o);
        // Drive bit set as software normally does.
        wb(1'b1, 8'h20, 32'h1);
        step(1);
        chk("drv oe", 32'hff, pb_o.oe);
        chk("drv ctl", 32'h1, mem_ctl_oe_o);
    endtask

    task automatic t_clk;
        wb(1'b1, 8'h24, 32'hf);
        prescaler_clock_i <= 1'b1;
        second_system_clock_i <= 1'b1;
        step(2);
        chk("clk mon a", 32'h5, pb_o.out[7:4]);
        @(posedge clk_i);
        {oscillator_clock_i, second_system_clock_i} <= 2'b10;
        {system_clock_i, prescaler_clock_i} <= 2'b10;
        step(2);
        chk("clk mon b", 32'ha, pb_o.out[7:4]);
        // GPIO on again must take pins 4-7 back from the clock select.
        wb(1'b1, 8'h00, 32'h0f);
        step(1);
        chk("gpio back", 32'h3, pb_o.out[7:4]);
    endtask

    task automatic t_pf;
        wb(1'b1, 8'h20, 32'h0);
        emi_dout_i <= 7'h55;
        external_memory_interface(1'b1, 1'b1);
        chk("d out", 32'h55, pf_o.out);
        chk("d oe", 32'h7f, pf_o.oe);
        @(posedge clk_i);
        mem_dat <= 7'h2a;
        mem_rd <= 1'b1;
        external_memory_interface(1'b1, 1'b0);
        step(1);
        chk("d in", 32'h2a, emi_din_o);
        @(posedge clk_i);
        mem_rd <= 1'b0;
        external_memory_interface(1'b0, 1'b0);
        chk("d idle", 32'h0, pf_o.oe);
        wb(1'b1, 8'h10, 32'h0);
        wb(1'b1, 8'h14, 32'haa00);
        wb(1'b1, 8'h18, 32'hfe00);
        step(1);
        chk("pf oe", 32'h55, pf_o.oe);
        chk("pf out", 32'h7f, pf_o.out);
    endtask

    // Mid-run reset with the interface mode strap; security decides.
    task automatic t_boot(input logic sec, input logic [31:0] e);
        @(posedge clk_i);
        rst_i <= 1'b1;
        {external_boot_select_i, memory_interface_mode_input_i} <= 2'b01;
        flash_secure_i <= sec;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 8'h00, 32'h0);
        chk("boot per", e, q);
        chk("boot pb pu", 32'hff, pb_o.pu);
        chk("boot d oe", 32'h0, pf_o.oe);
    endtask

    task automatic print_verdict;
        if (bad_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Main sequence; straps ask for address function on pins 0-3.
    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hf;
        {external_boot_select_i, memory_interface_mode_input_i} = 2'b10;
        flash_secure_i = 1'b1;
        {emi_active_i, emi_dout_en_i, emi_addr_i, emi_dout_i} = '0;
        emi_ctl_i = 3'h5;
        {prescaler_clock_i, system_clock_i} = 2'b00;
        {second_system_clock_i, oscillator_clock_i} = 2'b00;
        {mem_rd, mem_dat} = '0;
        step(2);
        chk("reset d oe", 32'h0, pf_o.oe);
        chk("reset d pu", 32'h7f, pf_o.pu);
        @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_gpio;
        t_pullup;
        t_addr;
        t_clk;
        t_pf;
        t_boot(1'b1, 32'h0);
        t_boot(1'b0, 32'hf);
        print_verdict;
    end

    // Whole run is about a hundred cycles; this cuts a hang short.
    initial begin
        repeat (3000) @(posedge clk_i);
        bad_count++;
        print_verdict;
    end
endmodule // ext_bus_gpio_pin_mux_tb
